// ### design/acc_pkg.sv
// Functional notes
// - Disabled in reset or channel all ones
// - Idle after completion without new start
// - Raw value 11 bits or 9 bits
// - Round to 10 or 8 bits, place
// - Set complete flag, interrupt when enabled
// - Compare enable checks every result
// - Four clock sources, bus clock at reset
// - Bus clock halved option, total sixteen
// - Async clock runs in wait and stop
// - Divider ratios one, two, four, eight
// - Pin control forces pin analog-only
// - Disabled input buffer reads as zero
// - Bits map to channels 8-15, 16-23
// - Hardware trigger rising edge starts conversion
// - Edge during conversion is ignored
// - Continuous hardware mode: first edge only
// - Software trigger on control-one write
// - Continuous mode restarts after each transfer
// - High read blocks transfer until low read, in 10-bit mode only
// - Blocked transfer restarts, except failed compare in single mode
// - Mode field picks 10 or 8 bits
// - Control-one write aborts running conversion
// - Greater select: flag when result >= compare
package acc_pkg;
  localparam logic [7:0] ADDR_SC1   = 8'h00;
  localparam logic [7:0] ADDR_SC2   = 8'h04;
  localparam logic [7:0] ADDR_RESH  = 8'h08;
  localparam logic [7:0] ADDR_RESL  = 8'h0C;
  localparam logic [7:0] ADDR_CVH   = 8'h10;
  localparam logic [7:0] ADDR_CVL   = 8'h14;
  localparam logic [7:0] ADDR_CFG   = 8'h18;
  localparam logic [7:0] ADDR_PIN1  = 8'h1C;
  localparam logic [7:0] ADDR_PIN2  = 8'h20;
  localparam logic [7:0] ADDR_PIN3  = 8'h24;
  localparam logic [4:0] CH_OFF     = 5'h1F;
  localparam logic [1:0] MODE_8     = 2'h0;
  localparam logic [1:0] MODE_10    = 2'h2;
  localparam logic [1:0] CLK_BUS    = 2'h0;
  localparam logic [1:0] CLK_BUS2   = 2'h1;
  localparam logic [1:0] CLK_ALT    = 2'h2;
  localparam logic [1:0] CLK_ASYNC  = 2'h3;
  localparam int         SAR_BITS10 = 11;
  localparam int         SAR_BITS8  = 9;
  localparam int         SAMPLE_CK  = 3;
  localparam logic [1:0] RESP_OK    = 2'h0;
  localparam logic [1:0] RESP_ERR   = 2'h2;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SAMP = 2'b01, ST_SAR = 2'b11,
                            ST_DONE = 2'b10} acc_state_type;
endpackage

// ### design/acc_top.sv
// The address map and register access over AXI4-Lite were chosen for this implementation.
module acc_top (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // Conversion clock sources and system mode
  input  wire logic        alt_clk_in,
  input  wire logic        async_clk_in,
  input  wire logic        stop_mode,
  // Hardware trigger
  input  wire logic        hardware_trigger_input,
  // Comparator from the analog array
  input  wire logic        cmp_hi,
  // Port pins 8..23
  input  wire logic [15:0] port_pin_in,
  output logic      [15:0] port_read,
  output logic      [15:0] pin_analog,
  // Status outputs
  output logic             irq,
  output logic             conv_active,
  output logic      [4:0]  channel_out,
  output logic      [10:0] dac_code,
  // AXI4-Lite
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic      [1:0]  bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  output logic             rvalid,
  input  wire logic        rready
);
  import acc_pkg::*;

  // Control registers
  logic [4:0]  channel_select_field;
  logic        completion_interrupt_enable;
  logic        continuous_conversion_enable;
  logic        hardware_trigger_enable;
  logic        compare_enable_bit;
  logic        compare_greater_select;
  logic [1:0]  input_clock_select_field;
  logic [1:0]  clock_divide_select_field;
  logic [1:0]  conv_mode;
  logic [2:0]  cfg_misc;
  logic [9:0]  cmp_val;
  logic [7:0]  analog_pin_disable_ch0_7;
  logic [7:0]  analog_pin_disable_ch8_15;
  logic [7:0]  analog_pin_disable_ch16_23;
  logic        conversion_complete_flag;
  logic [9:0]  result;
  logic        hi_read_lock;
  acc_state_type state;

  // Bus handshake state
  logic [7:0]  aw_q;
  logic [31:0] w_q;
  logic        aw_have;
  logic        w_have;
  logic        wr_go;
  logic        rd_go;
  logic        sc1_wr;
  logic        cfg_wr;

  assign wr_go  = aw_have && w_have && !bvalid;
  assign rd_go  = arvalid && arready;
  assign sc1_wr = wr_go && aw_q == ADDR_SC1 && w_q[0];
  // Any mode change invalidates a running conversion
  assign cfg_wr = wr_go && wstrb_ok(aw_q) && w_q[0];

  function automatic logic wstrb_ok(input logic [7:0] a);
    wstrb_ok = a == ADDR_SC2 || a == ADDR_CVH || a == ADDR_CVL || a == ADDR_CFG;
  endfunction

  // Write address and data taken in either order
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      aw_have <= 1'b0;
      w_have  <= 1'b0;
      aw_q    <= 8'h00;
      w_q     <= 32'h0000_0000;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OK;
    end
    else
    begin
      awready <= !aw_have && !awready;
      wready  <= !w_have && !wready;
      if (awvalid && awready)
      begin
        aw_have <= 1'b1;
        aw_q    <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_have <= 1'b1;
        w_q    <= {wdata[31:1], wstrb[0]};
      end
      if (wr_go)
      begin
        aw_have <= 1'b0;
        w_have  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= (aw_q > ADDR_PIN3 || aw_q[1:0] != 2'h0) ? RESP_ERR : RESP_OK;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // Holds byte-lane data separately since bit 0 carries the strobe
  logic [7:0] wbyte;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      wbyte <= 8'h00;
    else if (wvalid && wready)
      wbyte <= wdata[7:0];
  end

  // Register writes
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      channel_select_field         <= CH_OFF;
      completion_interrupt_enable  <= 1'b0;
      continuous_conversion_enable <= 1'b0;
      hardware_trigger_enable      <= 1'b0;
      compare_enable_bit           <= 1'b0;
      compare_greater_select       <= 1'b0;
      input_clock_select_field     <= CLK_BUS;
      clock_divide_select_field    <= 2'h0;
      conv_mode                    <= MODE_8;
      cfg_misc                     <= 3'h0;
      cmp_val                      <= 10'h000;
      analog_pin_disable_ch0_7     <= 8'h00;
      analog_pin_disable_ch8_15    <= 8'h00;
      analog_pin_disable_ch16_23   <= 8'h00;
    end
    else if (wr_go && w_q[0])
    begin
      unique case (aw_q)
        ADDR_SC1:
        begin
          completion_interrupt_enable  <= wbyte[6];
          continuous_conversion_enable <= wbyte[5];
          channel_select_field         <= wbyte[4:0];
        end
        ADDR_SC2:
        begin
          hardware_trigger_enable <= wbyte[6];
          compare_enable_bit      <= wbyte[5];
          compare_greater_select  <= wbyte[4];
        end
        ADDR_CVH:  cmp_val[9:8] <= wbyte[1:0];
        ADDR_CVL:  cmp_val[7:0] <= wbyte;
        ADDR_CFG:
        begin
          cfg_misc                  <= {wbyte[7], wbyte[4], 1'b0};
          clock_divide_select_field <= wbyte[6:5];
          conv_mode                 <= wbyte[3:2];
          input_clock_select_field  <= wbyte[1:0];
        end
        ADDR_PIN1: analog_pin_disable_ch0_7   <= wbyte;
        ADDR_PIN2: analog_pin_disable_ch8_15  <= wbyte;
        ADDR_PIN3: analog_pin_disable_ch16_23 <= wbyte;
        default:   ;
      endcase
    end
  end

  // Pin control, channels 8..23; a disabled buffer reads zero
  logic [15:0] pin_dis;
  logic [15:0] pin_s1;
  logic [15:0] pin_s2;
  assign pin_dis = {analog_pin_disable_ch16_23, analog_pin_disable_ch8_15};
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_s1     <= 16'h0000;
      pin_s2     <= 16'h0000;
      port_read  <= 16'h0000;
      pin_analog <= 16'h0000;
    end
    else
    begin
      pin_s1     <= port_pin_in;
      pin_s2     <= pin_s1;
      port_read  <= pin_s2 & ~pin_dis;
      pin_analog <= pin_dis;
    end
  end

  // Source clock sampling: slow sources pass a three-stage synchroniser
  logic [2:0] alt_sy;
  logic [2:0] asy_sy;
  logic       bus_half;
  logic       src_tick;
  logic       src_lvl;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      alt_sy   <= 3'h0;
      asy_sy   <= 3'h0;
      bus_half <= 1'b0;
    end
    else
    begin
      alt_sy   <= {alt_sy[1:0], alt_clk_in};
      asy_sy   <= {asy_sy[1:0], async_clk_in};
      bus_half <= !bus_half;
    end
  end

  // One tick per source period
  always_comb
  begin
    unique case (input_clock_select_field)
      CLK_BUS:  src_tick = 1'b1;
      CLK_BUS2: src_tick = bus_half;
      CLK_ALT:  src_tick = alt_sy[1] && !alt_sy[2];
      default:  src_tick = asy_sy[1] && !asy_sy[2];
    endcase
    src_lvl = src_tick;
  end

  // Divider 1/2/4/8 forms the converter clock enable
  logic [2:0] div_cnt;
  logic       converter_clock_tick;
  logic [2:0] div_mask;
  assign div_mask  = 3'((4'h1 << clock_divide_select_field) - 4'h1);
  assign converter_clock_tick = src_lvl && ((div_cnt & div_mask) == div_mask);
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      div_cnt <= 3'h0;
    else if (src_tick)
      div_cnt <= 3'(div_cnt + 3'h1);
  end

  // Async source keeps converting in stop; others abort there
  logic stop_abort;
  assign stop_abort = stop_mode && input_clock_select_field != CLK_ASYNC;

  // Hardware trigger edge detect
  logic [2:0] trg_sy;
  logic       trg_rise;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      trg_sy <= 3'h0;
    else
      trg_sy <= {trg_sy[1:0], hardware_trigger_input};
  end
  assign trg_rise = trg_sy[1] && !trg_sy[2];

  // Conversion sequencer
  logic [3:0]  bit_idx;
  logic [3:0]  samp_cnt;
  logic [10:0] sar;
  logic [10:0] raw;
  logic [9:0]  rounded;
  logic [9:0]  diff;
  logic [9:0]  cmp_ref;
  logic [10:0] bit_mask;
  logic        cmp_true;
  logic        blocked;
  logic        sw_start;
  logic        hw_start;
  logic        run_series;
  logic        is10;
  logic        done_evt;
  logic [3:0]  nbits;

  assign is10     = conv_mode == MODE_10;
  assign nbits    = is10 ? 4'(SAR_BITS10) : 4'(SAR_BITS8);
  // Trial bit is kept unless the comparator finds the input below the trial code
  assign bit_mask = 11'(11'h1 << bit_idx);
  assign raw      = cmp_hi ? sar : (sar & ~bit_mask);
  // Round half-LSB of the settled code: 11->10 and 9->8 bits, saturating at full scale
  assign rounded  = is10 ? ((sar[10:1] == 10'h3FF) ? 10'h3FF : 10'(sar[10:1] + sar[0]))
                         : ((sar[8:1] == 8'hFF) ? 10'h0FF : 10'({2'h0, sar[8:1]} + sar[0]));
  // Upper compare bits play no part in 8-bit mode
  assign cmp_ref  = is10 ? cmp_val : {2'h0, cmp_val[7:0]};
  assign diff     = 10'(rounded - cmp_ref);
  assign cmp_true = compare_greater_select ? (rounded >= cmp_ref)
                                           : (rounded < cmp_ref);
  assign blocked  = is10 && hi_read_lock;
  assign done_evt = state == ST_SAR && converter_clock_tick && bit_idx == 4'h0;
  assign sw_start = sc1_wr && !hardware_trigger_enable && wbyte[4:0] != CH_OFF;
  assign hw_start = hardware_trigger_enable && trg_rise && state == ST_IDLE
                    && !run_series && channel_select_field != CH_OFF;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state      <= ST_IDLE;
      bit_idx    <= 4'h0;
      samp_cnt   <= 4'h0;
      sar        <= 11'h000;
      dac_code   <= 11'h000;
      run_series <= 1'b0;
    end
    else if (sc1_wr || cfg_wr || stop_abort)
    begin
      state      <= (sc1_wr && sw_start) ? ST_SAMP : ST_IDLE;
      samp_cnt   <= 4'h0;
      sar        <= 11'h000;
      dac_code   <= 11'h000;
      run_series <= sc1_wr && sw_start && wbyte[5];
    end
    else if (channel_select_field == CH_OFF)
      state <= ST_IDLE;
    else
    begin
      unique case (state)
        ST_IDLE:
          if (hw_start)
          begin
            state      <= ST_SAMP;
            run_series <= continuous_conversion_enable;
            samp_cnt   <= 4'h0;
          end
        ST_SAMP:
          if (converter_clock_tick)
          begin
            samp_cnt <= 4'(samp_cnt + 4'h1);
            if (samp_cnt == 4'(SAMPLE_CK - 1))
            begin
              state    <= ST_SAR;
              bit_idx  <= 4'(nbits - 4'h1);
              sar      <= 11'(11'h1 << (nbits - 4'h1));
              dac_code <= 11'(11'h1 << (nbits - 4'h1));
            end
          end
        // Trial code leaves with the same edge as sar, so the comparator has settled
        ST_SAR:
          if (converter_clock_tick)
          begin
            if (bit_idx == 4'h0)
            begin
              sar      <= raw;
              dac_code <= raw;
              state    <= ST_DONE;
            end
            else
            begin
              sar      <= raw | (bit_mask >> 1);
              dac_code <= raw | (bit_mask >> 1);
              bit_idx  <= 4'(bit_idx - 4'h1);
            end
          end
        ST_DONE:
        begin
          samp_cnt <= 4'h0;
          // Blocked single compare-miss ends; other blocks restart
          if (blocked && !(compare_enable_bit && !cmp_true && !continuous_conversion_enable))
            state <= ST_SAMP;
          else if (continuous_conversion_enable)
            state <= ST_SAMP;
          else
          begin
            state      <= ST_IDLE;
            run_series <= 1'b0;
          end
        end
      endcase
    end
  end

  // Result transfer and complete flag; a new result wins over a read clear
  logic xfer;
  assign xfer = state == ST_DONE && !blocked && (!compare_enable_bit || cmp_true);
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      result                   <= 10'h000;
      conversion_complete_flag <= 1'b0;
    end
    else
    begin
      if (sc1_wr || cfg_wr)
        conversion_complete_flag <= 1'b0;
      else if (rd_go && araddr == ADDR_RESL)
        conversion_complete_flag <= 1'b0;
      if (xfer)
      begin
        result                   <= compare_enable_bit ? diff : rounded;
        conversion_complete_flag <= 1'b1;
      end
    end
  end

  // Read-lock between high and low result reads
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      hi_read_lock <= 1'b0;
    else if (rd_go && araddr == ADDR_RESH)
      hi_read_lock <= 1'b1;
    else if (rd_go && araddr == ADDR_RESL)
      hi_read_lock <= 1'b0;
  end

  // Read channel
  function automatic logic [7:0] rd_mux(input logic [7:0] a);
    unique case (a)
      ADDR_SC1:  rd_mux = {conversion_complete_flag, completion_interrupt_enable,
                           continuous_conversion_enable, channel_select_field};
      ADDR_SC2:  rd_mux = {state != ST_IDLE, hardware_trigger_enable,
                           compare_enable_bit, compare_greater_select, 4'h0};
      ADDR_RESH: rd_mux = is10 ? {6'h00, result[9:8]} : 8'h00;
      ADDR_RESL: rd_mux = result[7:0];
      ADDR_CVH:  rd_mux = {6'h00, cmp_val[9:8]};
      ADDR_CVL:  rd_mux = cmp_val[7:0];
      ADDR_CFG:  rd_mux = {cfg_misc[2], clock_divide_select_field, cfg_misc[1],
                           conv_mode, input_clock_select_field};
      ADDR_PIN1: rd_mux = analog_pin_disable_ch0_7;
      ADDR_PIN2: rd_mux = analog_pin_disable_ch8_15;
      ADDR_PIN3: rd_mux = analog_pin_disable_ch16_23;
      default:   rd_mux = 8'h00;
    endcase
  endfunction

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OK;
    end
    else
    begin
      arready <= !rvalid && !arready;
      if (rd_go)
      begin
        rvalid <= 1'b1;
        rdata  <= {24'h00_0000, rd_mux(araddr)};
        rresp  <= (araddr > ADDR_PIN3 || araddr[1:0] != 2'h0) ? RESP_ERR : RESP_OK;
      end
      else if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end

  // Registered status outputs
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      irq         <= 1'b0;
      conv_active <= 1'b0;
      channel_out <= CH_OFF;
    end
    else
    begin
      irq         <= conversion_complete_flag && completion_interrupt_enable;
      conv_active <= state != ST_IDLE;
      channel_out <= channel_select_field;
    end
  end

  // Checks
  completion_flag_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    xfer |=> conversion_complete_flag) else $error("flag not set on transfer");
  irq_follow_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (conversion_complete_flag && completion_interrupt_enable) |=> irq)
    else $error("irq missing");
  off_idle_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (channel_select_field == CH_OFF && !sc1_wr) |=> state == ST_IDLE)
    else $error("not disabled");
  block_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == ST_DONE && blocked) |=> $stable(result)) else $error("blocked write");
  port_zero_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    ##1 (port_read & $past(pin_dis)) == 16'h0000) else $error("disabled pin read");
  hw_ignore_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == ST_SAR && !sc1_wr && !cfg_wr && !stop_abort && !done_evt
     && channel_select_field != CH_OFF) |=> state == ST_SAR)
    else $error("edge restarted");
  sw_start_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    sw_start |=> state == ST_SAMP) else $error("no sw start");
  cont_restart_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == ST_DONE && continuous_conversion_enable && !sc1_wr && !cfg_wr && !stop_abort
     && channel_select_field != CH_OFF) |=> state == ST_SAMP)
    else $error("no restart");
  conv_cov: cover property (@(posedge clk_sys) disable iff (!rstn) xfer);
  block_cov: cover property (@(posedge clk_sys) disable iff (!rstn) state == ST_DONE && blocked);
  hw_cov: cover property (@(posedge clk_sys) disable iff (!rstn) hw_start);
endmodule

// ### tb/acc_far_model.sv
module acc_far_model (
  // Clock
  input  wire logic        clk_sys,
  // Analog side
  input  wire logic [10:0] dac_code,
  input  wire logic        mode8,
  input  wire logic [10:0] level,
  output logic             cmp_hi,
  // Trigger source
  output logic             hardware_trigger_input
);
  timeunit 1ns;
  timeprecision 1ns;

  // Keep trial bit while input is at or above it; a 9-bit code may sit low
  assign cmp_hi = (mode8 && dac_code < 11'h200) ? ({dac_code[8:0], 2'b00} <= level)
                                                : (dac_code <= level);

  // Trigger idles low
  initial hardware_trigger_input = 1'b0;

  // Pulse wide enough for a three-flop synchroniser
  task automatic fire();
    @(posedge clk_sys);
    hardware_trigger_input <= 1'b1;
    repeat (6) @(posedge clk_sys);
    hardware_trigger_input <= 1'b0;
  endtask
endmodule

// ### tb/acc_tb_top.sv
module acc_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import acc_pkg::*;

  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        alt_clk_in = 1'b0;
  logic        async_clk_in = 1'b0;
  logic        stop_mode = 1'b0;
  logic        m8 = 1'b1;
  logic [10:0] lvl = 11'h6A8;
  logic [15:0] port_pin_in = 16'hFFFF;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        hw_trig, cmp_hi, irq, conv_active, awready, wready, bvalid, arready, rvalid;
  logic [15:0] port_read, pin_analog;
  logic [4:0]  channel_out;
  logic [10:0] dac_code;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] rdata;
  int          num_errors = 0;
  int          checks_done = 0;

  // Bus clock and two unrelated conversion sources
  initial forever #50 clk_sys = ~clk_sys;
  initial forever #250 alt_clk_in = ~alt_clk_in;
  initial forever #370 async_clk_in = ~async_clk_in;

  acc_top uut (.clk_sys(clk_sys), .rstn(rstn), .alt_clk_in(alt_clk_in),
    .async_clk_in(async_clk_in), .stop_mode(stop_mode), .hardware_trigger_input(hw_trig),
    .cmp_hi(cmp_hi), .port_pin_in(port_pin_in), .port_read(port_read),
    .pin_analog(pin_analog), .irq(irq), .conv_active(conv_active),
    .channel_out(channel_out), .dac_code(dac_code), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  acc_far_model u_far (.clk_sys(clk_sys), .dac_code(dac_code), .mode8(m8), .level(lvl),
    .cmp_hi(cmp_hi), .hardware_trigger_input(hw_trig));

  // Verdict
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Compare and count
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Bound on every wait
  task automatic limit(input int k);
    if (k > 40000)
    begin
      num_errors++;
      report_and_stop();
    end
  endtask

  // Write: address and data offered together, held until taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      k++;
      limit(k);
    end
    while (!bvalid);
    bready <= 1'b0;
  endtask

  // Read and compare the low half
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    int k;
    k = 0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (arready)
        arvalid <= 1'b0;
      k++;
      limit(k);
    end
    while (!rvalid);
    rready <= 1'b0;
    rs = rresp;
    chk(rdata[15:0], e);
  endtask

  // Conversion end; the first cycles let the start land
  task automatic wait_idle();
    int k;
    k = 0;
    repeat (4) @(posedge clk_sys);
    while (conv_active)
    begin
      @(posedge clk_sys);
      k++;
      limit(k);
    end
    repeat (2) @(posedge clk_sys);
  endtask

  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    chk({conv_active, 10'h0, channel_out}, 16'h001F);
    chk(pin_analog, 16'h0);
    rdc(ADDR_SC1, 16'h1F);
    rdc(ADDR_CFG, 16'h00);
    rdc(8'h28, 16'h0);
    chk(16'(rs), 16'(RESP_ERR));
    wr(ADDR_PIN2, 8'hA5);
    wr(ADDR_PIN3, 8'h3C);
    repeat (6) @(posedge clk_sys);
    chk(pin_analog, 16'h3CA5);
    chk(port_read, 16'hC35A);
    rdc(ADDR_PIN3, 16'h3C);
    // Every clock source and divider, both modes
    for (int i = 0; i < 4; i++)
    begin
      m8 <= !i[0];
      wr(ADDR_CFG, {1'b0, i[1:0], 1'b0, i[0], 1'b0, i[1:0]});
      wr(ADDR_SC1, 8'h45);
      wait_idle();
      chk({irq, 10'h0, channel_out}, 16'h8005);
      rdc(ADDR_SC1, 16'hC5);
      rdc(ADDR_RESH, i[0] ? 16'h3 : 16'h0);
      rdc(ADDR_RESL, i[0] ? 16'h54 : 16'hD5);
      repeat (3) @(posedge clk_sys);
      chk({irq, conv_active}, 16'h0);
    end
    // High byte read blocks the next transfer
    wr(ADDR_SC1, 8'h05);
    wait_idle();
    rdc(ADDR_RESH, 16'h3);
    wr(ADDR_SC1, 8'h05);
    // Past one whole conversion, so the blocked result has been dropped
    repeat (1200) @(posedge clk_sys);
    rdc(ADDR_SC1, 16'h05);
    chk(16'(conv_active), 16'h1);
    rdc(ADDR_RESL, 16'h54);
    wait_idle();
    rdc(ADDR_SC1, 16'h85);
    rdc(ADDR_RESL, 16'h54);
    // Aborts, slow converter clock so the run is caught mid-way
    lvl <= 11'h5F0;
    wr(ADDR_CFG, 8'h68);
    wr(ADDR_SC1, 8'h05);
    repeat (20) @(posedge clk_sys);
    wr(ADDR_SC1, 8'h1F);
    repeat (3) @(posedge clk_sys);
    chk({conv_active, 10'h0, channel_out}, 16'h001F);
    rdc(ADDR_RESL, 16'h54);
    wr(ADDR_SC1, 8'h05);
    repeat (20) @(posedge clk_sys);
    wr(ADDR_SC1, 8'h05);
    wait_idle();
    rdc(ADDR_RESH, 16'h2);
    rdc(ADDR_RESL, 16'hF8);
    // Continuous: flag comes back after each clear
    wr(ADDR_CFG, 8'h08);
    wr(ADDR_SC1, 8'h25);
    for (int j = 0; j < 3; j++)
    begin
      rdc(ADDR_RESL, 16'hF8);
      repeat (200) @(posedge clk_sys);
      rdc(ADDR_SC1, 16'hA5);
    end
    wr(ADDR_SC1, 8'h1F);
    // Hardware trigger; a register write alone must not start
    lvl <= 11'h6A8;
    wr(ADDR_SC2, 8'h40);
    wr(ADDR_SC1, 8'h05);
    repeat (50) @(posedge clk_sys);
    chk(16'(conv_active), 16'h0);
    u_far.fire();
    wait_idle();
    rdc(ADDR_SC1, 16'h85);
    rdc(ADDR_RESL, 16'h54);
    // Compare, condition true then false
    wr(ADDR_SC2, 8'h30);
    wr(ADDR_CVH, 8'h03);
    wr(ADDR_CVL, 8'h00);
    wr(ADDR_SC1, 8'h05);
    wait_idle();
    rdc(ADDR_SC1, 16'h85);
    rdc(ADDR_RESH, 16'h0);
    rdc(ADDR_RESL, 16'h54);
    wr(ADDR_CVL, 8'hFF);
    wr(ADDR_SC1, 8'h05);
    wait_idle();
    rdc(ADDR_SC1, 16'h05);
    rdc(ADDR_RESL, 16'h54);
    // Stop: async source keeps converting, bus source aborts
    wr(ADDR_SC2, 8'h00);
    wr(ADDR_CFG, 8'h6B);
    wr(ADDR_SC1, 8'h05);
    stop_mode <= 1'b1;
    wait_idle();
    rdc(ADDR_SC1, 16'h85);
    wr(ADDR_CFG, 8'h08);
    wr(ADDR_SC1, 8'h05);
    repeat (3) @(posedge clk_sys);
    chk(16'(conv_active), 16'h0);
    stop_mode <= 1'b0;
    rdc(ADDR_SC1, 16'h05);
    report_and_stop();
  end
endmodule
